// ===== pkg/ssdi_pkg.sv
// constants, register map and types of the sensor indicator block
package ssdi_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] INPUT_OFF = 12'h004;
  localparam logic [11:0] STATE_OFF = 12'h008;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h00C;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h010;
  // control fields
  localparam int CTRL_READY_BIT = 0;
  localparam int CTRL_ACT_BIT = 1;
  localparam int CTRL_LIMIT_BIT = 2;
  localparam int CTRL_FAULT_LSB = 4;
  localparam int CTRL_RESET_BIT = 8;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET_VAL = 32'h0000_0000;
  // fault codes, value equals red flash count; internal is steady red
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_OUT_A = 3'h1;
  localparam logic [2:0] FLT_OUT_B = 3'h2;
  localparam logic [2:0] FLT_CROSS = 3'h3;
  localparam logic [2:0] FLT_TEMP = 3'h4;
  localparam logic [2:0] FLT_ACTUATOR = 3'h5;
  localparam logic [2:0] FLT_INTERNAL = 3'h7;
  // times and derived cycle counts at 250 MHz
  localparam longint CLK_HZ = 250_000_000;
  localparam longint WARN_MIN = 30;
  localparam longint WARN_CYC = WARN_MIN * 60 * CLK_HZ;
  localparam longint TICK_MS = 10;
  localparam longint TICK_CYC = TICK_MS * CLK_HZ / 1000;
  // flash timing in ticks of 10 ms
  localparam logic [7:0] PULSE_ON_TICKS = 8'h14;
  localparam logic [7:0] PULSE_OFF_TICKS = 8'h1E;
  localparam logic [7:0] CODE_PAUSE_TICKS = 8'h64;
  localparam logic [7:0] LIMIT_HALF_TICKS = 8'h19;
  // irq bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_FAILURE = 1;
  localparam int IRQ_LIMIT = 2;
  localparam int IRQ_W = 3;
  typedef enum logic [1:0] {SSDI_NORMAL, SSDI_WARN, SSDI_FAIL} ssdi_state_t;
endpackage : ssdi_pkg

// ===== rtl/ssdi_flash.sv
`timescale 1ns/1ps
// red flash code generator: n pulses, then a pause, repeated
module ssdi_flash (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic [2:0] code,
  // output
  output logic red
);
  typedef enum logic [1:0] {SSDI_F_IDLE, SSDI_F_ON, SSDI_F_OFF, SSDI_F_PAUSE} ssdi_fst_t;
  ssdi_fst_t st_r;
  logic [7:0] cnt_r;
  logic [2:0] num_r;
  logic active;
  assign active = (code != ssdi_pkg::FLT_NONE) && (code != ssdi_pkg::FLT_INTERNAL);
  always_ff @(posedge clk) begin
    if (rst || !active) begin
      st_r <= SSDI_F_IDLE;
      cnt_r <= 8'h00;
      num_r <= 3'h0;
    end else if (st_r == SSDI_F_IDLE) begin
      st_r <= SSDI_F_ON;
      cnt_r <= 8'h00;
      num_r <= 3'h1;
    end else if (tick) begin
      if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else begin
        unique case (st_r)
          SSDI_F_ON: begin
            st_r <= SSDI_F_OFF;
            cnt_r <= ssdi_pkg::PULSE_OFF_TICKS;
          end
          SSDI_F_OFF: begin
            if (num_r >= code) begin
              st_r <= SSDI_F_PAUSE;
              cnt_r <= ssdi_pkg::CODE_PAUSE_TICKS;
            end else begin
              st_r <= SSDI_F_ON;
              cnt_r <= ssdi_pkg::PULSE_ON_TICKS;
              num_r <= num_r + 3'h1;
            end
          end
          SSDI_F_PAUSE: begin
            st_r <= SSDI_F_ON;
            cnt_r <= ssdi_pkg::PULSE_ON_TICKS;
            num_r <= 3'h1;
          end
          SSDI_F_IDLE: begin
            st_r <= SSDI_F_ON;
          end
        endcase
      end
    end
  end
  assign red = (code == ssdi_pkg::FLT_INTERNAL) || (st_r == SSDI_F_ON);
endmodule : ssdi_flash

// ===== rtl/ssdi_top.sv
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
// Contract
// - green lit when ready and no fault or failure warning present
// - yellow lit while an actuator is detected, regardless of faults
// - limit area: yellow flashes, diagnostic output pulses, safety outputs on
// - any detected error activates the red indicator
// - red flash count encodes fault cause; internal error is steady red
// - active fault drives the diagnostic output low
// - unrectified fault switches safety outputs off within 30 minutes
// - warning period: green off, red flashes, yellow lit, diag low, safety on
// - failure: safety and diag off, red shows code, yellow with actuator
// - no actuator: only green, diag and safety outputs off
// - actuator and no fault: green, yellow, diag and safety outputs on
module ssdi_top #(
  parameter longint WARN_CYCLES = ssdi_pkg::WARN_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // sensor front end
  input wire logic ACT_PRESENT,
  input wire logic ACT_LIMIT,
  input wire logic [2:0] FAULT_CODE,
  input wire logic SAFETY_IN_OK,
  // indicators and outputs
  output logic LED_GREEN,
  output logic LED_RED,
  output logic LED_YELLOW,
  output logic DIAG_OUT,
  output logic SAFETY_OUTPUT_A,
  output logic SAFETY_OUTPUT_B,
  output logic IRQ
);
  logic [31:0] ctrl_r;
  logic [ssdi_pkg::IRQ_W-1:0] irq_stat_r;
  logic [ssdi_pkg::IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r;
  ssdi_pkg::ssdi_state_t st_r;
  logic [41:0] warn_cnt_r;
  logic [21:0] tick_cnt_r;
  logic [7:0] lim_cnt_r;
  logic lim_phase_r;
  logic led_g_r, led_r_r, led_y_r, diag_r, safe_r;
  logic [2:0] code_r;
  logic fault_prev_r, fail_prev_r, lim_prev_r;

  // bus decode
  wire wr_en = PSEL && PENABLE && PWRITE;
  wire rd_en = PSEL && PENABLE && !PWRITE;
  wire hit_ctrl = PADDR == ssdi_pkg::CTRL_OFF;
  wire hit_in = PADDR == ssdi_pkg::INPUT_OFF;
  wire hit_st = PADDR == ssdi_pkg::STATE_OFF;
  wire hit_is = PADDR == ssdi_pkg::IRQ_STAT_OFF;
  wire hit_im = PADDR == ssdi_pkg::IRQ_MASK_OFF;
  wire hit_any = hit_ctrl || hit_in || hit_st || hit_is || hit_im;

  // effective inputs: pins or software override
  wire ready = ctrl_r[ssdi_pkg::CTRL_READY_BIT];
  wire act = ACT_PRESENT || ctrl_r[ssdi_pkg::CTRL_ACT_BIT];
  wire limit = act && (ACT_LIMIT || ctrl_r[ssdi_pkg::CTRL_LIMIT_BIT]);
  wire [2:0] sw_code = ctrl_r[ssdi_pkg::CTRL_FAULT_LSB +: 3];
  wire [2:0] fcode = (FAULT_CODE != ssdi_pkg::FLT_NONE) ? FAULT_CODE : sw_code;
  wire fault = ready && (fcode != ssdi_pkg::FLT_NONE);
  wire internal = fcode == ssdi_pkg::FLT_INTERNAL;
  wire fail_reset = wr_en && hit_ctrl && PWDATA[ssdi_pkg::CTRL_RESET_BIT];
  wire tick = tick_cnt_r == 22'(ssdi_pkg::TICK_CYC - 1);
  wire warn_done = warn_cnt_r >= 42'(WARN_CYCLES - 1);
  wire red_flash;
  wire [ssdi_pkg::IRQ_W-1:0] irq_ev;

  assign irq_ev = {limit && !lim_prev_r, (st_r == ssdi_pkg::SSDI_FAIL) && !fail_prev_r,
                   fault && !fault_prev_r};

  ssdi_flash u_flash (
    .clk(MCLK),
    .rst(RST),
    .tick(tick),
    .code(code_r),
    .red(red_flash)
  );

  // register file and bus answer
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ctrl_r <= ssdi_pkg::CTRL_RESET_VAL;
      irq_mask_r <= ssdi_pkg::MASK_RESET_VAL[ssdi_pkg::IRQ_W-1:0];
      prdata_r <= 32'h0000_0000;
    end else begin
      if (wr_en && hit_ctrl) begin
        ctrl_r <= {24'h000000, 1'b0, PWDATA[6:0]};
      end
      if (wr_en && hit_im) begin
        irq_mask_r <= PWDATA[ssdi_pkg::IRQ_W-1:0];
      end
      if (PSEL && !PENABLE && !PWRITE) begin
        prdata_r <= hit_ctrl ? ctrl_r :
                    hit_in ? {26'h0, SAFETY_IN_OK, FAULT_CODE, ACT_LIMIT, ACT_PRESENT} :
                    hit_st ? {21'h0, st_r, fcode, 1'b0, SAFETY_OUTPUT_A,
                              DIAG_OUT, LED_YELLOW, LED_RED, LED_GREEN} :
                    hit_is ? {29'h0, irq_stat_r} :
                    hit_im ? {29'h0, irq_mask_r} : 32'h0000_0000;
      end
    end
  end

  // sticky status, set wins over write-one-clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && hit_is) ? PWDATA[2:0] : 3'h0)) | irq_ev;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      fault_prev_r <= 1'b0;
      fail_prev_r <= 1'b0;
      lim_prev_r <= 1'b0;
      tick_cnt_r <= '0;
    end else begin
      fault_prev_r <= fault;
      fail_prev_r <= st_r == ssdi_pkg::SSDI_FAIL;
      lim_prev_r <= limit;
      tick_cnt_r <= tick ? 22'h000000 : tick_cnt_r + 22'h000001;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_r <= ssdi_pkg::SSDI_NORMAL;
      warn_cnt_r <= '0;
      code_r <= ssdi_pkg::FLT_NONE;
    end else begin
      unique case (st_r)
        ssdi_pkg::SSDI_NORMAL: begin
          warn_cnt_r <= '0;
          if (fault && internal) begin
            st_r <= ssdi_pkg::SSDI_FAIL;
            code_r <= fcode;
          end else if (fault) begin
            st_r <= ssdi_pkg::SSDI_WARN;
            code_r <= fcode;
          end
        end
        ssdi_pkg::SSDI_WARN: begin
          warn_cnt_r <= warn_cnt_r + 42'h1;
          if (!fault) begin
            st_r <= ssdi_pkg::SSDI_NORMAL;
            code_r <= ssdi_pkg::FLT_NONE;
          end else if (warn_done || internal) begin
            st_r <= ssdi_pkg::SSDI_FAIL;
            code_r <= fcode;
          end else begin
            code_r <= fcode;
          end
        end
        ssdi_pkg::SSDI_FAIL: begin
          if (fail_reset && !fault) begin
            st_r <= ssdi_pkg::SSDI_NORMAL;
            code_r <= ssdi_pkg::FLT_NONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST || !limit) begin
      lim_cnt_r <= 8'h00;
      lim_phase_r <= 1'b1;
    end else if (tick) begin
      if (lim_cnt_r == ssdi_pkg::LIMIT_HALF_TICKS - 8'h01) begin
        lim_cnt_r <= 8'h00;
        lim_phase_r <= !lim_phase_r;
      end else begin
        lim_cnt_r <= lim_cnt_r + 8'h01;
      end
    end
  end

  // output next values
  wire normal = st_r == ssdi_pkg::SSDI_NORMAL;
  wire warn = st_r == ssdi_pkg::SSDI_WARN;
  // green only when ready and clean
  wire g_nxt = ready && normal && !fault;
  // yellow follows actuator, blinks in limit area
  wire y_nxt = act && (!limit || !normal || lim_phase_r);
  wire r_nxt = !normal && red_flash;
  // diag low on fault, pulsed in limit area
  wire d_nxt = ready && normal && !fault && act && (!limit || lim_phase_r);
  // safety held through warning, off on failure
  wire s_nxt = ready && act && (normal || warn) && SAFETY_IN_OK;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      led_g_r <= 1'b0;
      led_r_r <= 1'b0;
      led_y_r <= 1'b0;
      diag_r <= 1'b0;
      safe_r <= 1'b0;
    end else begin
      led_g_r <= g_nxt;
      led_r_r <= r_nxt;
      led_y_r <= y_nxt;
      diag_r <= d_nxt;
      safe_r <= s_nxt;
    end
  end

  assign LED_GREEN = led_g_r;
  assign LED_RED = led_r_r;
  assign LED_YELLOW = led_y_r;
  assign DIAG_OUT = diag_r;
  assign SAFETY_OUTPUT_A = safe_r;
  assign SAFETY_OUTPUT_B = safe_r;
  assign PRDATA = prdata_r;
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && !hit_any;
  assign IRQ = |(irq_stat_r & irq_mask_r);
endmodule : ssdi_top

// ===== sim/ssdi_chk.sv
// assertion checker for the sensor indicator block
`timescale 1ns/1ps
module ssdi_chk #(
  parameter longint WARN_CYCLES = 2000
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // sensor side
  input wire logic [2:0] FAULT_CODE,
  input wire logic SAFETY_IN_OK,
  input wire logic LED_GREEN,
  input wire logic DIAG_OUT,
  input wire logic SAFETY_OUTPUT_A,
  input wire logic SAFETY_OUTPUT_B
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [63:0] warn_r;
  // cycles spent warning: green off, safety still on
  always_ff @(posedge MCLK) begin
    if (RST || LED_GREEN || !SAFETY_OUTPUT_A) warn_r <= 64'h0;
    else warn_r <= warn_r + 64'h1;
  end
  zero_wait_a: assert property (PSEL && PENABLE |-> PREADY) else $error("no ready");
  bad_addr_a: assert property (PSEL && PENABLE && PADDR > 12'h010 |-> PSLVERR)
    else $error("no slave error");
  good_addr_a: assert property (PSEL && PENABLE && PADDR == 12'h010 |-> !PSLVERR)
    else $error("false slave error");
  safe_pair_a: assert property (SAFETY_OUTPUT_A == SAFETY_OUTPUT_B)
    else $error("safety outputs differ");
  fault_diag_a: assert property ((FAULT_CODE != 3'h0) [*3] |-> !DIAG_OUT && !LED_GREEN)
    else $error("fault not shown");
  chain_in_a: assert property ((!SAFETY_IN_OK) [*3] |-> !SAFETY_OUTPUT_A)
    else $error("safety on without chain input");
  internal_a: assert property ((FAULT_CODE == 3'h7) [*3] |-> !SAFETY_OUTPUT_A)
    else $error("internal fault kept outputs on");
  warn_len_a: assert property (warn_r <= WARN_CYCLES + 4)
    else $error("warning period too long");
endmodule : ssdi_chk
bind ssdi_top ssdi_chk #(.WARN_CYCLES(WARN_CYCLES)) u_ssdi_chk (
  .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .FAULT_CODE(FAULT_CODE),
  .SAFETY_IN_OK(SAFETY_IN_OK), .LED_GREEN(LED_GREEN), .DIAG_OUT(DIAG_OUT),
  .SAFETY_OUTPUT_A(SAFETY_OUTPUT_A), .SAFETY_OUTPUT_B(SAFETY_OUTPUT_B));

// ===== sim/ssdi_plc.sv
// safety controller and monitoring plc model
`timescale 1ns/1ps
module ssdi_plc (
  // clock
  input wire logic clk,
  // chain supply and sensor outputs
  input wire logic supply,
  input wire logic diag,
  input wire logic safe_a,
  input wire logic safe_b,
  // results
  output logic chain_ok,
  output logic stop_req
);
  assign chain_ok = supply;
  // controlled stop: diag low while safety still on
  always_ff @(posedge clk) stop_req <= safe_a & safe_b & ~diag;
endmodule : ssdi_plc

// ===== sim/testbench.sv
// self-checking bench of the sensor indicator block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module testbench;
  logic MCLK = 0, RST = 1, psel = 0, pen = 0, pwr = 0, act = 0, lim = 0, sup = 1;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, rdat;
  logic [2:0] flt = 3'h0;
  logic rerr, chain, stop;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, G, R, Y, D, SA, SB, IRQ;
  int n_errors = 0, n_checks = 0, cyc = 0;
  initial forever #2 MCLK = ~MCLK;
  ssdi_top #(.WARN_CYCLES(2000)) u_ssdi_top (.MCLK(MCLK), .RST(RST), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ACT_PRESENT(act), .ACT_LIMIT(lim),
    .FAULT_CODE(flt), .SAFETY_IN_OK(chain), .LED_GREEN(G), .LED_RED(R),
    .LED_YELLOW(Y), .DIAG_OUT(D), .SAFETY_OUTPUT_A(SA), .SAFETY_OUTPUT_B(SB), .IRQ(IRQ));
  ssdi_plc u_ssdi_plc (.clk(MCLK), .supply(sup), .diag(D), .safe_a(SA), .safe_b(SB),
    .chain_ok(chain), .stop_req(stop));
  task automatic give_verdict;
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
    @(posedge MCLK);
    pen <= 1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && n < 20) begin
      @(posedge MCLK);
      n++;
    end
    rdat = PRDATA;
    rerr = PSLVERR;
    psel <= 0; pen <= 0;
    @(posedge MCLK);
  endtask : apb
  task automatic waitc(input int n);
    repeat (n) @(posedge MCLK);
  endtask : waitc
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    waitc(6);
    RST <= 0;
    waitc(1);
    `CHK({G, R, Y, D, SA, IRQ}, 6'h00)
    apb(0, ssdi_pkg::CTRL_OFF, 0); `CHK(rdat, ssdi_pkg::CTRL_RESET_VAL)
    apb(0, ssdi_pkg::IRQ_MASK_OFF, 0); `CHK(rdat, ssdi_pkg::MASK_RESET_VAL)
    apb(0, 12'h020, 0); `CHK({rerr, rdat}, 33'h1_0000_0000)
    apb(1, ssdi_pkg::CTRL_OFF, 32'h1);
    waitc(4); `CHK({G, R, Y, D, SA, SB}, 6'b100000)
    apb(1, ssdi_pkg::CTRL_OFF, 32'h3);
    waitc(4); `CHK({G, Y, SA}, 3'b111)
    apb(1, ssdi_pkg::CTRL_OFF, 32'h1);
    act <= 1;
    waitc(4); `CHK({G, R, Y, D, SA, SB}, 6'b101111)
    sup <= 0;
    waitc(4); `CHK(SA, 1'b0)
    sup <= 1; lim <= 1;
    waitc(4); `CHK({Y, D, SA, SB}, 4'b1111)
    apb(0, ssdi_pkg::IRQ_STAT_OFF, 0); `CHK(rdat[2], 1'b1)
    lim <= 0;
    apb(1, ssdi_pkg::IRQ_MASK_OFF, 32'h7);
    `CHK(IRQ, 1'b1)
    apb(1, ssdi_pkg::IRQ_STAT_OFF, 32'h7);
    `CHK(IRQ, 1'b0)
    for (int c = 1; c < 6; c++) begin
      flt <= c[2:0];
      waitc(4); `CHK({G, Y, D, SA, stop}, 5'b01011)
      apb(0, ssdi_pkg::STATE_OFF, 0); `CHK(rdat[8:6], c[2:0])
      flt <= 0;
      waitc(4); `CHK({G, D}, 2'b11)
    end
    apb(1, ssdi_pkg::IRQ_STAT_OFF, 32'h7);
    flt <= ssdi_pkg::FLT_OUT_A;
    waitc(2100); `CHK({G, Y, D, SA, SB}, 5'b01000)
    apb(0, ssdi_pkg::IRQ_STAT_OFF, 0); `CHK({IRQ, rdat[1:0]}, 3'b111)
    flt <= 0;
    apb(1, ssdi_pkg::CTRL_OFF, 32'h101);
    waitc(4); `CHK({G, R, Y, D, SA, SB}, 6'b101111)
    apb(1, ssdi_pkg::CTRL_OFF, 32'h31);
    waitc(4); `CHK({G, D, SA}, 3'b001)
    apb(0, ssdi_pkg::STATE_OFF, 0); `CHK(rdat[8:6], 3'h3)
    apb(1, ssdi_pkg::CTRL_OFF, 32'h1);
    waitc(4); `CHK({G, D}, 2'b11)
    flt <= ssdi_pkg::FLT_INTERNAL;
    waitc(4); `CHK({G, R, D, SA}, 4'b0100)
    waitc(1000); `CHK(R, 1'b1)
    give_verdict();
  end
endmodule : testbench
